// ---- verilog/irq_ctl_pkg.sv ----
package irq_ctl_pkg;
  // ----------------------------------------
  // Bus and register addressing
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_RX_TX_A = 4'h3;
  localparam logic [3:0] ADDR_CMD_A = 4'h2;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_RX_TX_B = 4'hb;
  localparam logic [3:0] ADDR_CMD_B = 4'ha;
  localparam logic [3:0] ADDR_PORT_CHANGE = 4'h4;
  localparam logic [3:0] ADDR_OPCR = 4'hd;
  localparam logic [3:0] ADDR_STOP_CT = 4'hf;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int BIT_TX_A = 0;
  localparam int BIT_RX_A = 1;
  localparam int BIT_BRK_A = 2;
  localparam int BIT_CT = 3;
  localparam int BIT_TX_B = 4;
  localparam int BIT_RX_B = 5;
  localparam int BIT_BRK_B = 6;
  localparam int BIT_CHG = 7;
  localparam logic [3:0] CMD_RESET_BREAK = 4'h5;
  localparam int CMD_LSB = 4;
  localparam int CMD_W = 4;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] OPCR_RESET = 8'h00;
  localparam logic [3:0] CHG_RESET = 4'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NEGATE_MAX_NS = 300;
  localparam int NEGATE_MAX_CYC = NEGATE_MAX_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_req_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD = 2'b01,
    BUS_WR = 2'b10
  } bus_state_e;
endpackage

// ---- verilog/irq_ctl.sv ----
// Behaviour
// R01 - Access is chip select ANDed with strobe
// R02 - Host spaces same-command writes three clocks
// R03 - Host holds read strobe high 200 ns
// R04 - Single low interrupt from eight masked conditions
// R05 - Mask register selects interrupting conditions
// R06 - Status register readable shows active conditions
// R07 - Status shows one change bit, detail elsewhere
// R08 - Pins three to seven as discrete interrupts
// R09 - Receiver and transmitter pins as DMA requests
// R10 - Receive read negates receiver interrupt quickly
// R11 - Transmit write negates transmitter interrupt quickly
// R12 - Break reset command negates break interrupt
// R13 - Stop counter command negates counter interrupt
// R14 - Change register read negates change interrupt
// R15 - Mask clear removes contribution quickly
// R16 - Interrupt-type pins become open drain
// R17 - Counter bit set at each zero pass
// R18 - Change flags cleared by register read
// R19 - Strobes synchronised, one effect per access
// R20 - Interrupt low exactly when status and mask nonzero
module irq_ctl
  import irq_ctl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CHIP_SEL_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic RX_READY_A,
  input wire logic RX_READY_B,
  input wire logic RX_FIFO_FULL_A,
  input wire logic RX_FIFO_FULL_B,
  input wire logic TX_READY_A,
  input wire logic TX_READY_B,
  input wire logic BREAK_CHANGE_A,
  input wire logic BREAK_CHANGE_B,
  input wire logic CT_ZERO,
  input wire logic [3:0] INPUT_CHANGE,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  output logic IRQ_OUT_N,
  output logic [7:3] OP_OUT,
  output logic [7:3] OP_OE
);
  // ----------------------------------------
  // Strobe synchronisers
  // ----------------------------------------
  logic [1:0] rd_sync;
  logic [1:0] wr_sync;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [DATA_W-1:0] din_s1;
  logic [DATA_W-1:0] din_s2;
  logic [7:0] lvl_s1;
  logic [7:0] lvl_s2;
  logic [4:0] evt_s1;
  logic [4:0] evt_s2;
  logic [4:0] evt_d;
  bus_state_e state;
  bus_state_e next_state;
  bus_req_s req;

  // R01 - chip select AND
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_sync <= 2'b00;
      wr_sync <= 2'b00;
      addr_s1 <= '0;
      addr_s2 <= '0;
      din_s1 <= '0;
      din_s2 <= '0;
      lvl_s1 <= 8'h00;
      lvl_s2 <= 8'h00;
      evt_s1 <= 5'h00;
      evt_s2 <= 5'h00;
      evt_d <= 5'h00;
    end else begin
      rd_sync <= {rd_sync[0], ~CHIP_SEL_N & ~READ_STROBE_N};
      wr_sync <= {wr_sync[0], ~CHIP_SEL_N & ~WRITE_STROBE_N};
      addr_s1 <= ADDR;
      addr_s2 <= addr_s1;
      din_s1 <= DATA_IN;
      din_s2 <= din_s1;
      lvl_s1 <= {RX_READY_A, RX_READY_B, RX_FIFO_FULL_A, RX_FIFO_FULL_B,
                 TX_READY_A, TX_READY_B, BREAK_CHANGE_A, BREAK_CHANGE_B};
      lvl_s2 <= lvl_s1;
      evt_s1 <= {CT_ZERO, INPUT_CHANGE};
      evt_s2 <= evt_s1;
      evt_d <= evt_s2;
    end
  end

  // R19 - one pulse per access
  always_comb begin
    next_state = state;
    req = '0;
    req.addr = addr_s2;
    req.data = din_s2;
    case (state)
      BUS_IDLE: begin
        if (rd_sync[1]) begin
          next_state = BUS_RD;
          req.rd = 1'b1;
        end else if (wr_sync[1]) begin
          next_state = BUS_WR;
          req.wr = 1'b1;
        end
      end
      BUS_RD: begin
        if (!rd_sync[1]) next_state = BUS_IDLE;
      end
      BUS_WR: begin
        if (!wr_sync[1]) next_state = BUS_IDLE;
      end
      default: next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) state <= BUS_IDLE;
    else state <= next_state;
  end

  // ----------------------------------------
  // Interrupt state
  // ----------------------------------------
  logic [7:0] irq_mask_reg;
  logic [7:0] aux_control_reg;
  logic [7:0] opcr;
  logic [3:0] port_change_reg;
  logic ct_flag;
  logic [1:0] brk_flag;
  logic [1:0] tx_hold;
  logic [1:0] rx_hold;
  logic [7:0] next_mask;
  logic [7:0] next_aux;
  logic [7:0] next_opcr;
  logic [3:0] next_change;
  logic next_ct;
  logic [1:0] next_brk;
  logic [1:0] next_tx_hold;
  logic [1:0] next_rx_hold;
  logic [7:0] irq_status_reg;
  logic [DATA_W-1:0] next_dout;
  logic next_oe;
  logic next_irq_n;
  logic [7:3] next_op;
  logic [7:3] next_op_oe;
  logic [4:0] rise;

  function automatic logic is_cmd(input bus_req_s r, input logic [3:0] a);
    is_cmd = r.wr && (r.addr == a);
  endfunction

  always_comb begin
    rise = evt_s2 & ~evt_d;
    next_mask = irq_mask_reg;
    next_aux = aux_control_reg;
    next_opcr = opcr;
    next_change = port_change_reg;
    next_ct = ct_flag;
    next_brk = brk_flag;
    next_tx_hold = tx_hold;
    next_rx_hold = rx_hold;
    // R05 - mask write
    // R15 - mask clear
    if (is_cmd(req, ADDR_MASK)) next_mask = req.data;
    if (is_cmd(req, ADDR_AUX_CTRL)) next_aux = req.data;
    if (is_cmd(req, ADDR_OPCR)) next_opcr = req.data;
    // R10 - receive read hides ready until source drops
    if (req.rd && req.addr == ADDR_RX_TX_A) next_rx_hold[1] = 1'b1;
    if (req.rd && req.addr == ADDR_RX_TX_B) next_rx_hold[0] = 1'b1;
    if (!lvl_s2[7] && !lvl_s2[5]) next_rx_hold[1] = 1'b0;
    if (!lvl_s2[6] && !lvl_s2[4]) next_rx_hold[0] = 1'b0;
    // R11 - transmit write hides ready
    if (is_cmd(req, ADDR_RX_TX_A)) next_tx_hold[1] = 1'b1;
    if (is_cmd(req, ADDR_RX_TX_B)) next_tx_hold[0] = 1'b1;
    if (!lvl_s2[3]) next_tx_hold[1] = 1'b0;
    if (!lvl_s2[2]) next_tx_hold[0] = 1'b0;
    // R12 - break reset command
    if (is_cmd(req, ADDR_CMD_A) && req.data[CMD_LSB +: CMD_W] == CMD_RESET_BREAK)
      next_brk[1] = 1'b0;
    if (is_cmd(req, ADDR_CMD_B) && req.data[CMD_LSB +: CMD_W] == CMD_RESET_BREAK)
      next_brk[0] = 1'b0;
    if (lvl_s2[1]) next_brk[1] = 1'b1;
    if (lvl_s2[0]) next_brk[0] = 1'b1;
    // R13 - stop counter command
    if (req.rd && req.addr == ADDR_STOP_CT) next_ct = 1'b0;
    // R17 - set wins over clear
    if (rise[4]) next_ct = 1'b1;
    // R14 - R18 read clears change flags
    if (req.rd && req.addr == ADDR_PORT_CHANGE) next_change = CHG_RESET;
    next_change = next_change | rise[3:0];
    // R06 - R07 status image
    irq_status_reg = '0;
    irq_status_reg[BIT_TX_A] = lvl_s2[3] & ~tx_hold[1];
    irq_status_reg[BIT_TX_B] = lvl_s2[2] & ~tx_hold[0];
    irq_status_reg[BIT_RX_A] = (lvl_s2[7] | lvl_s2[5]) & ~rx_hold[1];
    irq_status_reg[BIT_RX_B] = (lvl_s2[6] | lvl_s2[4]) & ~rx_hold[0];
    irq_status_reg[BIT_BRK_A] = brk_flag[1];
    irq_status_reg[BIT_BRK_B] = brk_flag[0];
    irq_status_reg[BIT_CT] = ct_flag;
    irq_status_reg[BIT_CHG] = |(port_change_reg & aux_control_reg[3:0]);
    next_dout = DATA_OUT;
    next_oe = (state == BUS_RD) || req.rd;
    if (req.rd && req.addr == ADDR_STATUS) next_dout = irq_status_reg;
    else if (req.rd && req.addr == ADDR_PORT_CHANGE)
      next_dout = {DATA_W{1'b0}} | {4'h0, port_change_reg};
    // R04 - R20 combined output
    next_irq_n = ~|(irq_status_reg & irq_mask_reg);
    // R08 - R09 discrete pins, R16 open drain
    next_op = 5'h1f;
    next_op_oe = 5'h00;
    // Pin pulled low only while its condition is active
    if (opcr[4]) next_op_oe[3] = irq_status_reg[BIT_CT];
    if (opcr[5]) next_op_oe[4] = irq_status_reg[BIT_RX_A];
    if (opcr[6]) next_op_oe[5] = irq_status_reg[BIT_RX_B];
    if (opcr[7]) next_op_oe[6] = irq_status_reg[BIT_TX_A];
    if (opcr[3]) next_op_oe[7] = irq_status_reg[BIT_TX_B];
    next_op = ~next_op_oe & 5'h00;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_mask_reg <= MASK_RESET;
      aux_control_reg <= AUX_RESET;
      opcr <= OPCR_RESET;
      port_change_reg <= CHG_RESET;
      ct_flag <= 1'b0;
      brk_flag <= 2'b00;
      tx_hold <= 2'b00;
      rx_hold <= 2'b00;
      DATA_OUT <= '0;
      DATA_OE <= 1'b0;
      IRQ_OUT_N <= 1'b1;
      OP_OUT <= 5'h00;
      OP_OE <= 5'h00;
    end else begin
      irq_mask_reg <= next_mask;
      aux_control_reg <= next_aux;
      opcr <= next_opcr;
      port_change_reg <= next_change;
      ct_flag <= next_ct;
      brk_flag <= next_brk;
      tx_hold <= next_tx_hold;
      rx_hold <= next_rx_hold;
      DATA_OUT <= next_dout;
      DATA_OE <= next_oe;
      IRQ_OUT_N <= next_irq_n;
      OP_OUT <= next_op;
      OP_OE <= next_op_oe;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_irq_match;
    @(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> IRQ_OUT_N == ~|($past(irq_status_reg) & $past(irq_mask_reg));
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("irq mismatch"); // R20

  property p_one_pulse;
    @(posedge CLK_SYS) disable iff (RST)
      req.rd |=> !req.rd;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("double read"); // R19

  property p_chg_clear;
    @(posedge CLK_SYS) disable iff (RST)
      (req.rd && req.addr == ADDR_PORT_CHANGE && evt_s2[3:0] == evt_d[3:0]) |=>
        port_change_reg == 4'h0;
  endproperty
  a_chg_clear: assert property (p_chg_clear) else $error("change kept"); // R18

  property p_ct_set;
    @(posedge CLK_SYS) disable iff (RST)
      rise[4] |=> ct_flag;
  endproperty
  a_ct_set: assert property (p_ct_set) else $error("counter lost"); // R17

  property p_ct_stop;
    @(posedge CLK_SYS) disable iff (RST)
      (req.rd && req.addr == ADDR_STOP_CT && !rise[4]) |-> ##[1:2] IRQ_OUT_N || ct_flag == 1'b0;
  endproperty
  a_ct_stop: assert property (p_ct_stop) else $error("counter held"); // R13

  property p_mask_clear;
    @(posedge CLK_SYS) disable iff (RST)
      (is_cmd(req, ADDR_MASK) && req.data == 8'h00) |-> ##2 IRQ_OUT_N;
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask slow"); // R15

  property p_op_od;
    @(posedge CLK_SYS) disable iff (RST)
      1'b1 |-> OP_OUT == 5'h00;
  endproperty
  a_op_od: assert property (p_op_od) else $error("pin driven high"); // R16

  property p_dout_oe;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(DATA_OE) |-> $past(req.rd);
  endproperty
  a_dout_oe: assert property (p_dout_oe) else $error("stray drive"); // R06
endmodule // irq_ctl

// ---- tb/host_model.sv ----
// ----------------------------------------
// Host bus master
// ----------------------------------------
module host_model
  import irq_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic chip_sel_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  time t_start;
  initial begin
    chip_sel_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 4'h0;
    data_in = 8'h00;
    t_start = 0;
  end
  task access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
              output logic [DATA_W-1:0] q);
    @(negedge clk);
    addr = a;
    data_in = d;
    chip_sel_n = 1'b0;
    @(negedge clk);
    read_strobe_n = wr;
    write_strobe_n = !wr;
    t_start = $time;
    // Held 250 ns, above minimum pulse width
    repeat (25) @(negedge clk);
    q = data_oe ? data_out : 8'hxx;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    @(negedge clk);
    chip_sel_n = 1'b1;
    // Released lines show inverse, not stale value
    addr = ~a;
    data_in = ~d;
    // idle 200 ns also spaces commands
    repeat (20) @(negedge clk);
  endtask
endmodule // host_model

// ---- tb/tb_top.sv ----
// ----------------------------------------
// Interrupt control bench
// ----------------------------------------
module tb_top
  import irq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cs_n, rd_n, wr_n, oe, irq_n;
  logic [3:0] addr;
  logic [7:0] din, dout, q;
  logic [7:3] op_out, op_oe;
  // {ct, chg[3:0], brk b a, tx b a, full b a, rx b a}
  logic [12:0] src;
  int n_errors = 0;
  int checks_done = 0;
  time t_rise = 0;

  host_model host (.clk(clk), .data_out(dout), .data_oe(oe), .chip_sel_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .addr(addr), .data_in(din));

  irq_ctl DUT (.CLK_SYS(clk), .RST(rst), .CHIP_SEL_N(cs_n), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .ADDR(addr), .DATA_IN(din), .RX_READY_A(src[0]),
    .RX_READY_B(src[1]), .RX_FIFO_FULL_A(src[2]), .RX_FIFO_FULL_B(src[3]),
    .TX_READY_A(src[4]), .TX_READY_B(src[5]), .BREAK_CHANGE_A(src[6]),
    .BREAK_CHANGE_B(src[7]), .CT_ZERO(src[12]), .INPUT_CHANGE(src[11:8]),
    .DATA_OUT(dout), .DATA_OE(oe), .IRQ_OUT_N(irq_n), .OP_OUT(op_out), .OP_OE(op_oe));

  always @(posedge irq_n) t_rise = $time;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rd(input logic [3:0] a);
    host.access(1'b0, a, 8'h00, q);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task drive(input logic [12:0] v);
    @(negedge clk);
    src = v;
  endtask
  task automatic wait_irq(input logic v);
    for (int i = 0; i < 10 && irq_n !== v; i++) @(negedge clk);
    chk("irq_out_n", {7'h0, v}, {7'h0, irq_n});
  endtask
  // Release must land inside the window, not before the access
  task neg_chk(input string what);
    chk(what, 8'h01, {7'h0, t_rise > host.t_start && t_rise - host.t_start <= NEGATE_MAX_NS});
  endtask

  task t_reset;
    chk("reset irq", 8'h01, {7'h0, irq_n});
    chk("reset op_oe", 8'h00, {3'h0, op_oe});
    rd(ADDR_STATUS);
    chk("status", 8'h00, q);
    $display("test reset done");
  endtask
  task t_mask;
    drive(13'h0001);
    wait_irq(1'b1);
    rd(ADDR_STATUS);
    chk("status rx", 8'h02, q);
    wr(ADDR_MASK, 8'h02);
    wait_irq(1'b0);
    wr(ADDR_MASK, 8'h00);
    neg_chk("mask clear");
    $display("test mask done");
  endtask
  task t_rxtx;
    wr(ADDR_MASK, 8'h02);
    wait_irq(1'b0);
    rd(ADDR_RX_TX_A);
    neg_chk("rx read");
    drive(13'h0010);
    wr(ADDR_MASK, 8'h01);
    wait_irq(1'b0);
    wr(ADDR_RX_TX_A, 8'h5a);
    neg_chk("tx write");
    drive(13'h0040);
    wr(ADDR_MASK, 8'h04);
    wait_irq(1'b0);
    // Break level must drop first, a standing level sets the flag again
    drive(13'h0000);
    wr(ADDR_CMD_A, {CMD_RESET_BREAK, 4'h0});
    neg_chk("break reset");
    $display("test rxtx done");
  endtask
  task t_counter;
    wr(ADDR_MASK, 8'h08);
    drive(13'h1000);
    drive(13'h0000);
    wait_irq(1'b0);
    rd(ADDR_STATUS);
    chk("status ct", 8'h08, q);
    rd(ADDR_STOP_CT);
    neg_chk("stop counter");
    $display("test counter done");
  endtask
  task t_change;
    wr(ADDR_AUX_CTRL, 8'h01);
    wr(ADDR_MASK, 8'h80);
    drive(13'h0100);
    wait_irq(1'b0);
    rd(ADDR_STATUS);
    chk("status chg", 8'h80, q);
    rd(ADDR_PORT_CHANGE);
    chk("chg flags", 8'h01, {4'h0, q[3:0]});
    neg_chk("chg read");
    rd(ADDR_PORT_CHANGE);
    chk("chg cleared", 8'h00, {4'h0, q[3:0]});
    $display("test change done");
  endtask
  task t_pins;
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_OPCR, 8'h20);
    drive(13'h0001);
    repeat (10) @(negedge clk);
    chk("op_oe rx", 8'h02, {3'h0, op_oe});
    chk("op_out", 8'h00, {3'h0, op_out});
    chk("irq masked", 8'h01, {7'h0, irq_n});
    rd(ADDR_RX_TX_A);
    chk("op_oe off", 8'h00, {3'h0, op_oe});
    $display("test pins done");
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    // About 21 accesses of 48 clocks each
    #100us;
    n_errors++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    src = 13'h0000;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_mask;
    t_rxtx;
    t_counter;
    t_change;
    t_pins;
    stop_test;
  end
endmodule // tb_top
